// ---- rtl/sci_pkg.sv ----
// Shared constants for the serial channel configuration block.
package sci_pkg;

  // Bus geometry.
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam int          NUM_CH       = 2;
  localparam int          PRESC_CNT_W  = 15;

  // Register byte offsets, one aligned word each.
  localparam logic [7:0]  OFS_PRESCALE = 8'h00;
  localparam logic [7:0]  OFS_CLEAR0   = 8'h04;
  localparam logic [7:0]  OFS_CLEAR1   = 8'h08;
  localparam logic [7:0]  OFS_MODE_H   = 8'h0C;
  localparam logic [7:0]  OFS_MODE_L   = 8'h10;
  localparam logic [7:0]  OFS_COMM_H   = 8'h14;
  localparam logic [7:0]  OFS_DIVIDER  = 8'h18;
  localparam logic [7:0]  OFS_SO_LEVEL = 8'h1C;
  localparam logic [7:0]  OFS_CK_LEVEL = 8'h20;
  localparam logic [7:0]  OFS_STATUS   = 8'h24;
  localparam logic [7:0]  OFS_TXDATA   = 8'h28;
  localparam logic [7:0]  OFS_CLEAR_STEP = 8'h04;

  // Clear-trigger and status bit positions (status: channel n at bits 8n+2..8n).
  localparam int          CLR_OV       = 0;
  localparam int          CLR_PE       = 1;
  localparam int          CLR_FE       = 2;
  localparam int          STAT_STRIDE  = 8;
  localparam int          FE_CHANNEL   = 1;

  // Mode register fields.
  localparam int          MH_CKS       = 7;
  localparam int          MH_CCS       = 6;
  localparam int          ML_MD_LSB    = 1;
  localparam int          ML_IS        = 0;
  localparam logic [7:0]  MH_MASK      = 8'hC0;
  localparam logic [7:0]  ML_MASK      = 8'h07;
  localparam logic [7:0]  ML_FIXED     = 8'h20;

  // Communication setup fields.
  localparam int          CS_TXE       = 7;
  localparam int          CS_RXE       = 6;
  localparam int          CS_EOC       = 2;
  localparam logic [7:0]  CS_MASK      = 8'hC4;

  // Divider field lives in bits 7..1, bit 0 is fixed at zero.
  localparam logic [7:0]  DIV_MASK     = 8'hFE;
  localparam logic [7:0]  LEVEL_MASK   = 8'h03;

  // Operating mode codes.
  localparam logic [1:0]  MODE_CSI     = 2'h0;
  localparam logic [1:0]  MODE_UART    = 2'h1;
  localparam logic [1:0]  MODE_I2C     = 2'h2;
  localparam logic [1:0]  MODE_BAD     = 2'h3;

  // Reset values.
  localparam logic [7:0]  RST_PRESCALE = 8'h00;
  localparam logic [7:0]  RST_MODE_H   = 8'h00;
  localparam logic [7:0]  RST_MODE_L   = 8'h20;
  localparam logic [7:0]  RST_COMM_H   = 8'h00;
  localparam logic [7:0]  RST_DIVIDER  = 8'h00;
  localparam logic [7:0]  RST_LEVEL    = 8'h03;

endpackage

// ---- rtl/sci_i2c_setup.sv ----
// Configuration, clock generation and event routing for one serial channel pair.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module sci_i2c_setup #(
  parameter int TXQ_DEPTH = 2,
  parameter int TXQ_W     = 8
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [sci_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [sci_pkg::DATA_W-1:0]  pwdata,
  output logic      [sci_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        sck_in,
  input  wire logic                        xfer_end,
  input  wire logic                        rx_done,
  input  wire logic [sci_pkg::NUM_CH-1:0]  fe_evt,
  input  wire logic [sci_pkg::NUM_CH-1:0]  pe_evt,
  input  wire logic [sci_pkg::NUM_CH-1:0]  ov_evt,
  input  wire logic                        tx_ready,
  output logic                             tx_valid,
  output logic      [TXQ_W-1:0]            tx_data,
  output logic                             tclk,
  output logic      [1:0]                  mode,
  output logic                             tx_en,
  output logic                             rx_en,
  output logic      [sci_pkg::NUM_CH-1:0]  sdata_out,
  output logic      [sci_pkg::NUM_CH-1:0]  sclk_out,
  output logic                             irq_send,
  output logic                             irq_recv,
  output logic                             irq_recv_err
);
  import sci_pkg::*;
  localparam int CNT_W = $clog2(TXQ_DEPTH + 1);

  logic [7:0]             presc_q, mode_h_q, mode_l_q, comm_q, div_q;
  logic [NUM_CH-1:0]      so_q, cko_q, fe_q, pe_q, ov_q;
  logic [PRESC_CNT_W-1:0] presc_cnt_q;
  logic [1:0]             op_tick_q;
  logic [6:0]             div_cnt_q;
  logic                   tclk_int_q, tclk_q, pready_q, pslverr_q, mapped_d;
  logic [DATA_W-1:0]      prdata_q, prdata_d;
  logic                   irq_send_q, irq_recv_q, irq_recv_err_q;
  logic [TXQ_W-1:0]       txq_mem_q [TXQ_DEPTH];
  logic [CNT_W-1:0]       txq_cnt_q;
  logic                   txq_valid_q, txq_full, txq_push, txq_pop;
  logic                   acc, wr_done, mck_tick, any_err;

  // An access completes on the edge where pready is high; a push into a full queue waits.
  assign acc      = psel && penable && !pready_q;
  assign wr_done  = psel && penable && pready_q && pwrite;
  assign txq_full = (txq_cnt_q == CNT_W'(TXQ_DEPTH));
  assign txq_push = wr_done && (paddr == OFS_TXDATA);
  assign txq_pop  = txq_valid_q && tx_ready;

  // APB answer: one wait state, longer only while the transmit queue is full.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end
    else
    begin
      pready_q  <= acc && !(pwrite && (paddr == OFS_TXDATA) && txq_full && !txq_pop);
      pslverr_q <= acc && !mapped_d;
      prdata_q  <= (acc && !pwrite) ? prdata_d : '0;
    end
  end

  // Read decode; write-only clear triggers and the data port read as zero.
  always_comb
  begin
    prdata_d = '0;
    mapped_d = 1'b1;
    case (paddr)
      OFS_PRESCALE: prdata_d[7:0] = presc_q;
      OFS_MODE_H:   prdata_d[7:0] = mode_h_q;
      OFS_MODE_L:   prdata_d[7:0] = mode_l_q;
      OFS_COMM_H:   prdata_d[7:0] = comm_q;
      OFS_DIVIDER:  prdata_d[7:0] = div_q;
      OFS_SO_LEVEL: prdata_d[NUM_CH-1:0] = so_q;
      OFS_CK_LEVEL: prdata_d[NUM_CH-1:0] = cko_q;
      OFS_STATUS:
      begin
        for (int c = 0; c < NUM_CH; c++)
        begin
          prdata_d[c*STAT_STRIDE+CLR_OV] = ov_q[c];
          prdata_d[c*STAT_STRIDE+CLR_PE] = pe_q[c];
          prdata_d[c*STAT_STRIDE+CLR_FE] = fe_q[c];
        end
      end
      OFS_CLEAR0, OFS_CLEAR1, OFS_TXDATA: prdata_d = '0;
      default:      mapped_d = 1'b0;
    endcase
  end

  // Configuration registers; fixed and reserved bits are masked on write.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      presc_q  <= RST_PRESCALE;
      mode_h_q <= RST_MODE_H;
      mode_l_q <= RST_MODE_L;
      comm_q   <= RST_COMM_H;
      div_q    <= RST_DIVIDER;
      so_q     <= RST_LEVEL[NUM_CH-1:0];
      cko_q    <= RST_LEVEL[NUM_CH-1:0];
    end
    else if (wr_done)
    begin
      case (paddr)
        OFS_PRESCALE: presc_q  <= pwdata[7:0];
        OFS_MODE_H:   mode_h_q <= pwdata[7:0] & MH_MASK;
        OFS_MODE_L:
        begin
          // A prohibited mode write is dropped so the channel keeps a legal mode.
          if (pwdata[ML_MD_LSB+:2] != MODE_BAD)
            mode_l_q <= (pwdata[7:0] & ML_MASK) | ML_FIXED;
        end
        OFS_COMM_H:   comm_q   <= pwdata[7:0] & CS_MASK;
        OFS_DIVIDER:  div_q    <= pwdata[7:0] & DIV_MASK;
        OFS_SO_LEVEL: so_q     <= pwdata[NUM_CH-1:0];
        OFS_CK_LEVEL: cko_q    <= pwdata[NUM_CH-1:0];
        default:      presc_q  <= presc_q;
      endcase
    end
  end

  // Free-running prescaler; a tick every 2^k cycles when the low k bits are all ones.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      presc_cnt_q <= '0;
    else
      presc_cnt_q <= presc_cnt_q + PRESC_CNT_W'(1);
  end

  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_opclk
      logic [3:0]             k;
      logic [PRESC_CNT_W-1:0] mask;
      assign k    = presc_q[4*g+:4];
      assign mask = ~(PRESC_CNT_W'({PRESC_CNT_W{1'b1}} << k));
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          op_tick_q[g] <= 1'b0;
        else
          op_tick_q[g] <= &(presc_cnt_q | ~mask);
      end
    end
  endgenerate

  // Channel operating clock chooses one of the two prescaled ticks.
  assign mck_tick = mode_h_q[MH_CKS] ? op_tick_q[1] : op_tick_q[0];

  // Half period is divider field plus one ticks, so a full period is twice that.
  // A disabled channel parks its divided clock high, like an idle bus.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt_q  <= '0;
      tclk_int_q <= 1'b1;
    end
    else if (!comm_q[CS_TXE] && !comm_q[CS_RXE])
    begin
      div_cnt_q  <= '0;
      tclk_int_q <= 1'b1;
    end
    else if (mck_tick)
    begin
      if (div_cnt_q >= div_q[7:1])
      begin
        div_cnt_q  <= '0;
        tclk_int_q <= !tclk_int_q;
      end
      else
        div_cnt_q <= div_cnt_q + 7'h01;
    end
  end

  // Source select: the pin clock only makes sense for a clocked-serial slave.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tclk_q <= 1'b1;
    else
      tclk_q <= mode_h_q[MH_CCS] ? sck_in : tclk_int_q;
  end

  // Error flags; a new error in the clear cycle wins so no event is lost.
  generate
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_flags
      logic clr_wr;
      assign clr_wr = wr_done && (paddr == OFS_CLEAR0 + 8'(c) * OFS_CLEAR_STEP);
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pe_q[c] <= 1'b0;
          ov_q[c] <= 1'b0;
        end
        else
        begin
          pe_q[c] <= pe_evt[c] || (pe_q[c] && !(clr_wr && pwdata[CLR_PE]));
          ov_q[c] <= ov_evt[c] || (ov_q[c] && !(clr_wr && pwdata[CLR_OV]));
        end
      end
      if (c == FE_CHANNEL)
      begin : g_fe
        always_ff @(posedge pclk or negedge presetn)
        begin
          if (!presetn)
            fe_q[c] <= 1'b0;
          else
            fe_q[c] <= fe_evt[c] || (fe_q[c] && !(clr_wr && pwdata[CLR_FE]));
        end
      end
      else
      begin : g_no_fe
        // This channel has no framing check, so its flag and clear bit do not exist.
        assign fe_q[c] = 1'b0;
      end
    end
  endgenerate

  // Two-entry transmit queue; entry 0 is the head so data leaves straight from a flop.
  generate
    for (genvar e = 0; e < TXQ_DEPTH; e++)
    begin : g_txq
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          txq_mem_q[e] <= '0;
        else if (txq_pop)
        begin
          if (txq_push && (CNT_W'(e + 1) == txq_cnt_q))
            txq_mem_q[e] <= pwdata[TXQ_W-1:0];
          else if (e < TXQ_DEPTH - 1)
            txq_mem_q[e] <= txq_mem_q[(e < TXQ_DEPTH - 1) ? e + 1 : e];
        end
        else if (txq_push && (CNT_W'(e) == txq_cnt_q))
          txq_mem_q[e] <= pwdata[TXQ_W-1:0];
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      txq_cnt_q   <= '0;
      txq_valid_q <= 1'b0;
    end
    else
    begin
      txq_cnt_q   <= txq_cnt_q + CNT_W'(txq_push) - CNT_W'(txq_pop);
      txq_valid_q <= (txq_cnt_q + CNT_W'(txq_push) - CNT_W'(txq_pop)) != '0;
    end
  end

  // Interrupt routing; each request is a one-cycle pulse.
  assign any_err = fe_evt[FE_CHANNEL] || pe_evt[0] || ov_evt[0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_send_q     <= 1'b0;
      irq_recv_q     <= 1'b0;
      irq_recv_err_q <= 1'b0;
    end
    else
    begin
      // With the IS bit set, buffer-empty fires when the head word moves into the shifter; with it clear, on xfer_end.
      irq_send_q     <= comm_q[CS_TXE] &&
                        (mode_l_q[ML_IS] ? txq_pop : xfer_end);
      // With the mask set, an errored reception raises only the error request.
      irq_recv_q     <= comm_q[CS_RXE] && rx_done && !(any_err && comm_q[CS_EOC]);
      irq_recv_err_q <= comm_q[CS_RXE] && rx_done && any_err && comm_q[CS_EOC];
    end
  end

  // Output drive, all from flops.
  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign tx_valid     = txq_valid_q;
  assign tx_data      = txq_mem_q[0];
  assign tclk         = tclk_q;
  assign mode         = mode_l_q[ML_MD_LSB+:2];
  assign tx_en        = comm_q[CS_TXE];
  assign rx_en        = comm_q[CS_RXE];
  assign sdata_out    = so_q;
  assign sclk_out     = cko_q;
  assign irq_send     = irq_send_q;
  assign irq_recv     = irq_recv_q;
  assign irq_recv_err = irq_recv_err_q;

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_clear_pe1;
    wr_done && (paddr == OFS_CLEAR1) && pwdata[CLR_PE] && !pe_evt[1];
  endsequence
  a_pe_clear_works: assert property (s_clear_pe1 |=> !pe_q[1])
    else $error("parity flag survived a clear");
  a_ov_set_wins: assert property (ov_evt[0] |=> ov_q[0])
    else $error("overrun event lost");
  a_fe_clear_works: assert property (wr_done && (paddr == OFS_CLEAR1) && pwdata[CLR_FE]
                                     && !fe_evt[1] |=> !fe_q[1])
    else $error("framing flag survived a clear");
  a_fe_absent_ch0: assert property (fe_q[0] == 1'b0)
    else $error("channel 0 framing flag set");
  a_mode_never_bad: assert property (mode != MODE_BAD)
    else $error("prohibited mode reached");
  a_so_level_follow: assert property (wr_done && (paddr == OFS_SO_LEVEL)
                                      |=> sdata_out == $past(pwdata[NUM_CH-1:0]))
    else $error("data level not applied");
  a_cko_level_follow: assert property (wr_done && (paddr == OFS_CK_LEVEL)
                                       |=> sclk_out == $past(pwdata[NUM_CH-1:0]))
    else $error("clock level not applied");
  a_err_irq_route: assert property (rx_done && any_err && rx_en && comm_q[CS_EOC]
                                    |=> irq_recv_err && !irq_recv)
    else $error("error request misrouted");
  a_tclk_source: assert property (mode_h_q[MH_CCS] && $stable(mode_h_q)
                                  |=> tclk == $past(sck_in))
    else $error("pin clock not selected");
  a_buf_empty_irq: assert property (tx_en && mode_l_q[ML_IS] && txq_pop
                                    |=> irq_send)
    else $error("buffer empty request missing");
  a_div_idle_high: assert property (!tx_en && !rx_en ##1 !tx_en && !rx_en
                                    |-> tclk_int_q)
    else $error("disabled channel clock not parked");

endmodule

`default_nettype wire

// ---- verification/sci_sink_model.sv ----
// Far-side shifter model that takes transmit words, promptly or with stalls.
`timescale 1ns/1ps
`default_nettype none

module sci_sink_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic hold,
  output logic      tx_ready,
  output logic      sck_in
);
  // The far side clocks the pin only while it is busy with a frame.
  // The line is pulled up, so it stands high between frames.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sck_in <= 1'b1;
    else
      sck_in <= hold ? !sck_in : 1'b1;
  end

  // Accept on a random half of the cycles, so the buffer sees real stalls.
  // Hold forces a long stall so that the producer side is made to wait.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_ready <= 1'b0;
    else
      tx_ready <= !hold && ($urandom % 2 == 0);
  end
endmodule

`default_nettype wire

// ---- verification/sci_i2c_setup_tb.sv ----
// Self-checking bench for the serial channel configuration block.
`timescale 1ns/1ps
`default_nettype none

module sci_i2c_setup_tb;
  import sci_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sck_in;
  logic        xfer_end, rx_done, tx_ready, tx_valid, tclk, tx_en, rx_en, hold;
  logic        irq_send, irq_recv, irq_recv_err, third_done, tclk_a;
  logic [7:0]  paddr, tx_data;
  logic [31:0] pwdata, prdata;
  logic [1:0]  fe_evt, pe_evt, ov_evt, mode, sdata_out, sclk_out;
  logic [32:0] apb_q[$];
  logic [7:0]  byte_q[$];
  int          miscompares = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          sends = 0;
  time         t0;
  logic [7:0]  ra[9] = '{OFS_PRESCALE, OFS_MODE_H, OFS_MODE_L, OFS_COMM_H, OFS_DIVIDER,
                         OFS_SO_LEVEL, OFS_CK_LEVEL, OFS_STATUS, OFS_CLEAR1};
  logic [7:0]  rv[9] = '{RST_PRESCALE, RST_MODE_H, RST_MODE_L, RST_COMM_H, RST_DIVIDER,
                         RST_LEVEL, RST_LEVEL, 8'h00, 8'h00};
  logic [7:0]  wa[4] = '{OFS_PRESCALE, OFS_MODE_H, OFS_COMM_H, OFS_DIVIDER};
  logic [7:0]  wm[4] = '{8'hFF, MH_MASK, CS_MASK, DIV_MASK};
  logic [7:0]  ca[6] = '{OFS_CLEAR0, OFS_CLEAR0, OFS_CLEAR0, OFS_CLEAR1, OFS_CLEAR1, OFS_CLEAR1};
  logic [7:0]  cd[6] = '{8'h04, 8'h01, 8'h02, 8'h00, 8'h04, 8'h03};
  logic [31:0] ce[6] = '{32'h703, 32'h702, 32'h700, 32'h700, 32'h300, 32'h0};
  logic [7:0]  icm[4] = '{8'hC0, 8'hC0, 8'hC4, 8'hC4};
  logic [7:0]  iev[4] = '{8'h80, 8'h44, 8'h44, 8'h40};
  logic [2:0]  iex[4] = '{3'h4, 3'h2, 3'h1, 3'h2};

  sci_i2c_setup sci_i2c_setup_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sck_in, .xfer_end, .rx_done, .fe_evt, .pe_evt, .ov_evt, .tx_ready,
    .tx_valid, .tx_data, .tclk, .mode, .tx_en, .rx_en, .sdata_out, .sclk_out,
    .irq_send, .irq_recv, .irq_recv_err
  );

  sci_sink_model sci_sink_model_inst (
    .pclk, .presetn, .hold, .tx_ready, .sck_in
  );

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One APB transfer; the expected error flag and read data go to the monitor queue.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [31:0] e, input logic err);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    apb_q.push_back({err, w ? 32'h0 : e});
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00, e, 1'b0);
  endtask

  // Event pulses last one cycle; the pulse answer is settled right after the next edge.
  task automatic fire(input logic [7:0] m);
    @(posedge pclk);
    {xfer_end, rx_done, fe_evt, pe_evt, ov_evt} <= m;
    @(posedge pclk);
    {xfer_end, rx_done, fe_evt, pe_evt, ov_evt} <= 8'h00;
    #1;
  endtask

  // The first interval after a setting change may be partial, so skip it.
  task automatic meas(input int exp);
    @(tclk);
    @(tclk);
    t0 = $time;
    @(tclk);
    chk(33'(($time - t0) / 10), 33'(exp));
  endtask

  // Monitor: completions and popped words are matched against the oldest note.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      summarize();
    end
    if (psel && penable && pready === 1'b1 && apb_q.size() > 0)
      chk({pslverr, pwrite ? 32'h0 : prdata}, apb_q.pop_front());
    if (tx_valid === 1'b1 && tx_ready === 1'b1 && byte_q.size() > 0)
      chk(33'(tx_data), 33'(byte_q.pop_front()));
    if (irq_send === 1'b1)
      sends++;
  end

  initial
  begin
    {psel, penable, pwrite, xfer_end, rx_done, hold, paddr, pwdata} = '0;
    {fe_evt, pe_evt, ov_evt} = '0;
    presetn = 1'b0;
    void'($urandom(53));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk({tclk, mode, sdata_out, sclk_out, tx_valid}, 33'h9E);
    foreach (ra[i])
      rd(ra[i], 32'(rv[i]));
    foreach (wa[i])
    begin
      wr(wa[i], 8'hFF);
      rd(wa[i], 32'(wm[i]));
    end
    apb(1'b0, 8'h2C, 8'h00, 32'h0, 1'b1);
    apb(1'b1, 8'h30, 8'hFF, 32'h0, 1'b1);
    wr(OFS_SO_LEVEL, 8'h01);
    wr(OFS_CK_LEVEL, 8'h02);
    #1;
    chk({sdata_out, sclk_out}, 33'h6);
    wr(OFS_SO_LEVEL, 8'h03);
    wr(OFS_CK_LEVEL, 8'h03);
    #1;
    chk({sdata_out, sclk_out}, 33'hF);
    for (int m = 0; m < 3; m++)
    begin
      wr(OFS_MODE_L, 8'(m * 2));
      #1;
      chk(33'(mode), 33'(m));
      rd(OFS_MODE_L, 32'(ML_FIXED | 8'(m * 2)));
    end
    // The prohibited mode code must leave the previous mode in place.
    wr(OFS_MODE_L, 8'h06);
    rd(OFS_MODE_L, 32'(ML_FIXED | 8'h04));
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_COMM_H, 8'(i << 6));
      #1;
      chk({tx_en, rx_en}, 33'(i));
    end
    fire(8'h3F);
    rd(OFS_STATUS, 32'h703);
    foreach (ca[i])
    begin
      wr(ca[i], cd[i]);
      rd(OFS_STATUS, ce[i]);
    end
    foreach (icm[i])
    begin
      wr(OFS_COMM_H, icm[i]);
      fire(iev[i]);
      chk({irq_send, irq_recv, irq_recv_err}, 33'(iex[i]));
    end
    // Fill the buffer while the far side stalls, then drain it at random pace.
    wr(OFS_MODE_L, 8'h05);
    wr(OFS_COMM_H, 8'hC0);
    sends = 0;
    third_done = 1'b0;
    hold <= 1'b1;
    fork
      begin
        for (int i = 0; i < 3; i++)
        begin
          byte_q.push_back(8'($urandom));
          wr(OFS_TXDATA, byte_q[$]);
        end
        third_done = 1'b1;
      end
      begin
        // The busy far side clocks the pin, and the pin-clock source must pass it on.
        repeat (39) @(posedge pclk);
        tclk_a = tclk;
        @(posedge pclk);
        chk({tx_valid, third_done, tclk ^ tclk_a}, 33'h5);
        hold <= 1'b0;
      end
    join
    repeat (40) @(posedge pclk);
    #1;
    chk(33'(byte_q.size()), 33'h0);
    chk(33'(sends), 33'h3);
    wr(OFS_PRESCALE, 8'h12);
    wr(OFS_DIVIDER, 8'h06);
    wr(OFS_MODE_H, 8'h00);
    meas(16);
    wr(OFS_MODE_H, 8'h80);
    meas(8);
    wr(OFS_COMM_H, 8'h00);
    repeat (40) @(posedge pclk);
    #1;
    chk(33'(tclk), 33'h1);
    summarize();
  end
endmodule

`default_nettype wire
